// ==== rtl/interval_timer.sv ====
// Overview of operation
// - Address lines pick counter or control word
// - Data bus floats while chip select high
// - Control word: select, access, mode, BCD
// - Counters decrement on clock falling edge
// - Mode 0 output low, high at end
// - Mode 0 low gate pauses counting
// - Mode 0 rewrite: stop first, restart second
// - Mode 1 gate edge starts low pulse
// - Mode 1 new count leaves pulse alone
// - Mode 2 one low clock every n
// - Mode 2 new count after current period
// - Mode 2 low gate forces high, restarts
// - Mode 2 idle high until count written
// - Mode 3 square wave, odd split
// - Mode 3 new rate at next half
// - Mode 3 gate behaves as mode 2
// - Mode 4 single one-clock low strobe
// - Mode 4 rewrite affects next strobe only
// - Mode 5 gate edge starts strobe count
// - Two-byte read: low then high
// - Latch command freezes count for reading
`timescale 1ns/10ps
`default_nettype none
module interval_timer (
   input  wire logic        CLK_SYS,
   input  wire logic        RST_N,
   input  wire logic        CS_N,
   input  wire logic        RD_N,
   input  wire logic        WR_N,
   input  wire logic        PORT_SELECT_LOW,
   input  wire logic        PORT_SELECT_HIGH,
   input  wire logic [7:0]  DATA_IN,
   output logic      [7:0]  DATA_OUT,
   output logic             DATA_OE,
   input  wire logic [2:0]  TIMER_CLK,
   input  wire logic [2:0]  TIMER_GATE,
   output logic      [2:0]  TIMER_OUT
);
   localparam int N = interval_timer_pkg::NUM_CH;

   // ---------------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------------
   // Binary or BCD down count by one
   function automatic logic [15:0] dec_count(input logic [15:0] v,
                                             input logic        bcd);
      logic [15:0] r;
      logic        borrow;
      r      = v;
      borrow = 1'b1;
      if (!bcd) begin
         r = v - interval_timer_pkg::CNT_ONE;
      end else begin
         for (int d = 0; d < 4; d++) begin
            if (borrow) begin
               if (r[4*d +: 4] == 4'h0) begin
                  r[4*d +: 4] = 4'h9;
               end else begin
                  r[4*d +: 4] = r[4*d +: 4] - 4'h1;
                  borrow = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction

   // Length of a square-wave half; high half takes the odd clock
   function automatic logic [15:0] half_count(input logic [15:0] n,
                                              input logic        hi);
      logic [16:0] w;
      w = (n == 16'h0000) ? interval_timer_pkg::CNT_FULL : {1'b0, n};
      w = hi ? ((w + 17'h0_0001) >> 1) : (w >> 1);
      return w[15:0];
   endfunction

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   logic [12:0] bus_s1_ff, bus_s2_ff;
   logic [2:0]  tclk_s1_ff, tclk_s2_ff, tclk_prev_ff;
   logic [2:0]  gate_s1_ff, gate_s2_ff, gate_prev_ff;
   logic        rdp_ff, wrp_ff;

   // Two stages on every pin, plus edge history
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         bus_s1_ff    <= 13'h1_C00;
         bus_s2_ff    <= 13'h1_C00;
         tclk_s1_ff   <= 3'h0;
         tclk_s2_ff   <= 3'h0;
         tclk_prev_ff <= 3'h0;
         gate_s1_ff   <= 3'h0;
         gate_s2_ff   <= 3'h0;
         gate_prev_ff <= 3'h0;
         rdp_ff       <= 1'b0;
         wrp_ff       <= 1'b0;
      end else begin
         bus_s1_ff    <= {CS_N, RD_N, WR_N, PORT_SELECT_HIGH,
                          PORT_SELECT_LOW, DATA_IN};
         bus_s2_ff    <= bus_s1_ff;
         tclk_s1_ff   <= TIMER_CLK;
         tclk_s2_ff   <= tclk_s1_ff;
         tclk_prev_ff <= tclk_s2_ff;
         gate_s1_ff   <= TIMER_GATE;
         gate_s2_ff   <= gate_s1_ff;
         gate_prev_ff <= gate_s2_ff;
         rdp_ff       <= ~bus_s2_ff[12] & ~bus_s2_ff[11];
         wrp_ff       <= ~bus_s2_ff[12] & ~bus_s2_ff[10];
      end
   end

   logic       cs_act, rd_act, wr_act, wr_ev, rd_done;
   logic [1:0] addr;
   logic [7:0] din;
   logic [2:0] tick, grise;

   // Strobe decode; a write lands as the write strobe ends
   assign cs_act  = ~bus_s2_ff[12];
   assign rd_act  = ~bus_s2_ff[11];
   assign wr_act  = ~bus_s2_ff[10];
   assign addr    = bus_s2_ff[9:8];
   assign din     = bus_s2_ff[7:0];
   assign wr_ev   = wrp_ff & ~wr_act;
   assign rd_done = rdp_ff & ~rd_act;
   assign tick    = tclk_prev_ff & ~tclk_s2_ff;
   assign grise   = gate_s2_ff & ~gate_prev_ff;

   // ---------------------------------------------------------------
   // Counter channels
   // ---------------------------------------------------------------
   logic [N-1:0][2:0]  mode_ff, nxt_mode;
   logic [N-1:0][1:0]  rl_ff, nxt_rl;
   logic [N-1:0][15:0] cnt_ff, nxt_cnt, init_ff, nxt_init;
   logic [N-1:0][15:0] lat_ff, nxt_lat;
   logic [N-1:0][7:0]  lo_ff, nxt_lo;
   logic [N-1:0]       bcd_ff, nxt_bcd, out_ff, nxt_out, run_ff, nxt_run;
   logic [N-1:0]       pend_ff, nxt_pend, armed_ff, nxt_armed;
   logic [N-1:0]       wptr_ff, nxt_wptr, rptr_ff, nxt_rptr;
   logic [N-1:0]       latv_ff, nxt_latv;
   logic [7:0]         nxt_dout;
   logic               nxt_oe;

   // Next state of every channel and of the data bus driver
   always_comb begin
      logic [2:0]  m;
      logic [2:0]  cm;
      logic [15:0] nv, rv;
      logic        trig_mode, en;
      m = 3'h0;
      cm = 3'h0;
      nv = 16'h0000;
      rv = 16'h0000;
      trig_mode = 1'b0;
      en = 1'b0;
      nxt_mode = mode_ff;   nxt_rl = rl_ff;     nxt_cnt = cnt_ff;
      nxt_init = init_ff;   nxt_lat = lat_ff;   nxt_lo = lo_ff;
      nxt_bcd = bcd_ff;     nxt_out = out_ff;   nxt_run = run_ff;
      nxt_pend = pend_ff;   nxt_armed = armed_ff;
      nxt_wptr = wptr_ff;   nxt_rptr = rptr_ff; nxt_latv = latv_ff;
      nxt_dout = 8'h00;
      for (int i = 0; i < N; i++) begin
         m = mode_ff[i];
         trig_mode = (m == interval_timer_pkg::MODE_ONESHOT) ||
                     (m == interval_timer_pkg::MODE_HWSTB);
         en = gate_s2_ff[i] | trig_mode;
         // Control word write to this channel
         if (wr_ev && addr == interval_timer_pkg::ADDR_CTRL &&
             din[interval_timer_pkg::CW_SEL_HI:
                 interval_timer_pkg::CW_SEL_LO] == 2'(i)) begin
            if (din[interval_timer_pkg::CW_RL_HI:
                    interval_timer_pkg::CW_RL_LO] ==
                interval_timer_pkg::RL_LATCH) begin
               if (!latv_ff[i]) begin
                  nxt_lat[i]  = cnt_ff[i];
                  nxt_latv[i] = 1'b1;
               end
            end else begin
               cm = din[interval_timer_pkg::CW_MODE_HI:
                        interval_timer_pkg::CW_MODE_LO];
               if (cm[2:1] == 2'h3) cm = {1'b0, cm[1:0]};
               nxt_mode[i]  = cm;
               nxt_rl[i]    = din[interval_timer_pkg::CW_RL_HI:
                                  interval_timer_pkg::CW_RL_LO];
               nxt_bcd[i]   = din[interval_timer_pkg::CW_BCD];
               nxt_out[i]   = (cm != interval_timer_pkg::MODE_TC);
               nxt_run[i]   = 1'b0;
               nxt_pend[i]  = 1'b0;
               nxt_armed[i] = 1'b0;
               nxt_wptr[i]  = 1'b0;
               nxt_rptr[i]  = 1'b0;
               nxt_latv[i]  = 1'b0;
            end
         end
         // Count write to this channel
         if (wr_ev && addr == 2'(i) &&
             rl_ff[i] != interval_timer_pkg::RL_LATCH) begin
            if (m == interval_timer_pkg::MODE_TC) begin
               nxt_run[i] = 1'b0;
               nxt_out[i] = 1'b0;
            end
            if (rl_ff[i] == interval_timer_pkg::RL_BOTH && !wptr_ff[i]) begin
               nxt_lo[i]   = din;
               nxt_wptr[i] = 1'b1;
            end else begin
               case (rl_ff[i])
                  interval_timer_pkg::RL_LOW:  nv = {8'h00, din};
                  interval_timer_pkg::RL_HIGH: nv = {din, 8'h00};
                  default:                     nv = {din, lo_ff[i]};
               endcase
               nxt_init[i]  = nv;
               nxt_wptr[i]  = 1'b0;
               nxt_armed[i] = 1'b1;
               if (!trig_mode) nxt_pend[i] = 1'b1;
            end
         end
         // Gate handling for the rate modes and the gate-triggered modes
         if ((m == interval_timer_pkg::MODE_RATE ||
              m == interval_timer_pkg::MODE_SQUARE) && !gate_s2_ff[i]) begin
            nxt_run[i] = 1'b0;
            nxt_out[i] = 1'b1;
         end
         if (grise[i] && armed_ff[i] && m != interval_timer_pkg::MODE_TC &&
             m != interval_timer_pkg::MODE_SWSTB)
            nxt_pend[i] = 1'b1;
         // Counting on a falling timer clock edge
         if (tick[i]) begin
            if (pend_ff[i] && en && (!run_ff[i] || trig_mode)) begin
               nxt_cnt[i]  = (m == interval_timer_pkg::MODE_SQUARE) ?
                             half_count(init_ff[i], 1'b1) : init_ff[i];
               nxt_run[i]  = 1'b1;
               nxt_pend[i] = 1'b0;
               nxt_out[i]  = (m != interval_timer_pkg::MODE_ONESHOT) &&
                             (m != interval_timer_pkg::MODE_TC);
            end else if (run_ff[i] && en) begin
               nv = dec_count(cnt_ff[i], bcd_ff[i]);
               case (m)
                  interval_timer_pkg::MODE_TC,
                  interval_timer_pkg::MODE_ONESHOT: begin
                     nxt_cnt[i] = nv;
                     if (cnt_ff[i] == interval_timer_pkg::CNT_ONE)
                        nxt_out[i] = 1'b1;
                  end
                  interval_timer_pkg::MODE_RATE: begin
                     if (cnt_ff[i] == interval_timer_pkg::CNT_ONE) begin
                        nxt_cnt[i]  = init_ff[i];
                        nxt_out[i]  = 1'b1;
                        nxt_pend[i] = 1'b0;
                     end else begin
                        nxt_cnt[i] = nv;
                        nxt_out[i] = (nv != interval_timer_pkg::CNT_ONE);
                     end
                  end
                  interval_timer_pkg::MODE_SQUARE: begin
                     if (cnt_ff[i] == interval_timer_pkg::CNT_ONE) begin
                        nxt_out[i]  = ~out_ff[i];
                        nxt_cnt[i]  = half_count(init_ff[i], ~out_ff[i]);
                        nxt_pend[i] = 1'b0;
                     end else begin
                        nxt_cnt[i] = nv;
                     end
                  end
                  default: begin
                     if (!out_ff[i]) begin
                        nxt_out[i] = 1'b1;
                        nxt_run[i] = 1'b0;
                     end else if (cnt_ff[i] == interval_timer_pkg::CNT_ONE) begin
                        nxt_out[i] = 1'b0;
                        nxt_cnt[i] = 16'h0000;
                     end else begin
                        nxt_cnt[i] = nv;
                     end
                  end
               endcase
            end
         end
         // Read byte selection and read completion
         rv = latv_ff[i] ? lat_ff[i] : cnt_ff[i];
         if (addr == 2'(i))
            nxt_dout = (rl_ff[i] == interval_timer_pkg::RL_HIGH ||
                        (rl_ff[i] == interval_timer_pkg::RL_BOTH &&
                         rptr_ff[i])) ? rv[15:8] : rv[7:0];
         if (rd_done && addr == 2'(i)) begin
            if (rl_ff[i] == interval_timer_pkg::RL_BOTH && !rptr_ff[i]) begin
               nxt_rptr[i] = 1'b1;
            end else begin
               nxt_rptr[i] = 1'b0;
               nxt_latv[i] = 1'b0;
            end
         end
      end
      nxt_oe = cs_act & rd_act & ~wr_act &
               (addr != interval_timer_pkg::ADDR_CTRL);
   end

   // Channel and bus driver registers
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         mode_ff <= '0;  rl_ff <= '0;   cnt_ff <= '0;  init_ff <= '0;
         lat_ff <= '0;   lo_ff <= '0;   bcd_ff <= '0;  out_ff <= '0;
         run_ff <= '0;   pend_ff <= '0; armed_ff <= '0;
         wptr_ff <= '0;  rptr_ff <= '0; latv_ff <= '0;
         DATA_OUT <= 8'h00;
         DATA_OE  <= 1'b0;
      end else begin
         mode_ff <= nxt_mode;  rl_ff <= nxt_rl;     cnt_ff <= nxt_cnt;
         init_ff <= nxt_init;  lat_ff <= nxt_lat;   lo_ff <= nxt_lo;
         bcd_ff <= nxt_bcd;    out_ff <= nxt_out;   run_ff <= nxt_run;
         pend_ff <= nxt_pend;  armed_ff <= nxt_armed;
         wptr_ff <= nxt_wptr;  rptr_ff <= nxt_rptr; latv_ff <= nxt_latv;
         DATA_OUT <= nxt_dout;
         DATA_OE  <= nxt_oe;
      end
   end

   assign TIMER_OUT = out_ff;

   // ---------------------------------------------------------------
   // Assertions on channel 0 and the bus
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);

   sequence s_cw0(logic [2:0] md);
      wr_ev && addr == interval_timer_pkg::ADDR_CTRL && din[7:6] == 2'h0 &&
      din[5:4] != interval_timer_pkg::RL_LATCH && din[3:1] == md;
   endsequence
   sequence s_latch0;
      wr_ev && addr == interval_timer_pkg::ADDR_CTRL && din[7:4] == 4'h0 &&
      !latv_ff[0];
   endsequence

   property p_float_cs;
      !cs_act |=> !DATA_OE;
   endproperty
   a_float_cs: assert property (p_float_cs)
      else $error("Data bus driven while deselected");
   property p_float_ctrl;
      addr == interval_timer_pkg::ADDR_CTRL |=> !DATA_OE;
   endproperty
   a_float_ctrl: assert property (p_float_ctrl)
      else $error("Data bus driven at control address");
   property p_m0_low;
      wr_ev && addr == 2'h0 && mode_ff[0] == interval_timer_pkg::MODE_TC &&
      rl_ff[0] != interval_timer_pkg::RL_LATCH |=> !out_ff[0] && !run_ff[0];
   endproperty
   a_m0_low: assert property (p_m0_low)
      else $error("Mode 0 count write did not drive output low");
   property p_m2_idle;
      s_cw0(interval_timer_pkg::MODE_RATE) |=> out_ff[0] && !run_ff[0] ##1
      (!run_ff[0] || armed_ff[0])[*2];
   endproperty
   a_m2_idle: assert property (p_m2_idle)
      else $error("Mode 2 left idle without a count");
   property p_dec;
      tick[0] && run_ff[0] && !pend_ff[0] && gate_s2_ff[0] && !wr_ev &&
      mode_ff[0] == interval_timer_pkg::MODE_TC
      |=> cnt_ff[0] == dec_count($past(cnt_ff[0]), bcd_ff[0]);
   endproperty
   a_dec: assert property (p_dec)
      else $error("Counter did not step down by one");
   property p_gate_hold;
      mode_ff[0] == interval_timer_pkg::MODE_TC && !gate_s2_ff[0] &&
      !wr_ev |=> $stable(cnt_ff[0]);
   endproperty
   a_gate_hold: assert property (p_gate_hold)
      else $error("Mode 0 counted with gate low");
   property p_rate_gate;
      mode_ff[0] == interval_timer_pkg::MODE_RATE && !gate_s2_ff[0]
      |=> out_ff[0] && !run_ff[0];
   endproperty
   a_rate_gate: assert property (p_rate_gate)
      else $error("Low gate did not force mode 2 output high");
   property p_strobe_end;
      tick[0] && !out_ff[0] && run_ff[0] && !wr_ev &&
      mode_ff[0] == interval_timer_pkg::MODE_SWSTB
      |=> out_ff[0] && !run_ff[0];
   endproperty
   a_strobe_end: assert property (p_strobe_end)
      else $error("Mode 4 strobe longer than one clock");
   property p_latch;
      s_latch0 |=> latv_ff[0] && lat_ff[0] == $past(cnt_ff[0]);
   endproperty
   a_latch: assert property (p_latch)
      else $error("Latch command did not capture the count");
   property p_rd_pair;
      rd_done && addr == 2'h0 && rl_ff[0] == interval_timer_pkg::RL_BOTH &&
      !rptr_ff[0] && !wr_ev |=> rptr_ff[0];
   endproperty
   a_rd_pair: assert property (p_rd_pair)
      else $error("First read did not advance to high byte");
endmodule
`default_nettype wire

// ==== rtl/interval_timer_pkg.sv ====
`default_nettype none
package interval_timer_pkg;
   // ---------------------------------------------------------------
   // Register addresses
   // ---------------------------------------------------------------
   localparam logic [1:0] ADDR_CNT0   = 2'h0;
   localparam logic [1:0] ADDR_CNT1   = 2'h1;
   localparam logic [1:0] ADDR_CNT2   = 2'h2;
   localparam logic [1:0] ADDR_CTRL   = 2'h3;
   localparam int         NUM_CH      = 3;
   // ---------------------------------------------------------------
   // Control word fields
   // ---------------------------------------------------------------
   localparam int         CW_SEL_HI   = 7;
   localparam int         CW_SEL_LO   = 6;
   localparam int         CW_RL_HI    = 5;
   localparam int         CW_RL_LO    = 4;
   localparam int         CW_MODE_HI  = 3;
   localparam int         CW_MODE_LO  = 1;
   localparam int         CW_BCD      = 0;
   // Byte access codes
   localparam logic [1:0] RL_LATCH    = 2'h0;
   localparam logic [1:0] RL_LOW      = 2'h1;
   localparam logic [1:0] RL_HIGH     = 2'h2;
   localparam logic [1:0] RL_BOTH     = 2'h3;
   // Counter modes
   localparam logic [2:0] MODE_TC     = 3'h0;
   localparam logic [2:0] MODE_ONESHOT = 3'h1;
   localparam logic [2:0] MODE_RATE   = 3'h2;
   localparam logic [2:0] MODE_SQUARE = 3'h3;
   localparam logic [2:0] MODE_SWSTB  = 3'h4;
   localparam logic [2:0] MODE_HWSTB  = 3'h5;
   // Counter values
   localparam logic [15:0] CNT_ONE    = 16'h0001;
   localparam logic [16:0] CNT_FULL   = 17'h1_0000;
endpackage
`default_nettype wire

// ==== sim/host_bus_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
   input  wire logic       clk_sys,
   input  wire logic [7:0] data_out,
   input  wire logic       data_oe,
   output logic            cs_n,
   output logic            rd_n,
   output logic            wr_n,
   output logic            port_select_low,
   output logic            port_select_high,
   output logic      [7:0] data_in
);
   // ---------------------------------------------------------------
   // Idle bus levels
   // ---------------------------------------------------------------
   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      port_select_low = 1'b0;
      port_select_high = 1'b0;
      data_in = 8'h00;
   end

   // ---------------------------------------------------------------
   // Bus cycles
   // ---------------------------------------------------------------
   // Write: strobe low 3 cycles, address and data held 4 more
   task automatic bus_write(input logic [1:0] adr, input logic [7:0] dat);
      @(posedge clk_sys);
      #1;
      {port_select_high, port_select_low} = adr;
      data_in = dat;
      cs_n = 1'b0;
      wr_n = 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      wr_n = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      cs_n = 1'b1;
      data_in = ~dat;  // Released bus must not show the old byte
      repeat (2) @(posedge clk_sys);
      #1;
   endtask

   // Read: wait a bounded time for the device to drive the bus
   task automatic bus_read(input logic [1:0] adr, output logic [7:0] dat,
                           output logic oe_seen);
      int n;
      @(posedge clk_sys);
      #1;
      {port_select_high, port_select_low} = adr;
      cs_n = 1'b0;
      rd_n = 1'b0;
      oe_seen = 1'b0;
      dat = 8'h00;
      // Sample just after the edge so the registered answer has settled
      for (n = 0; n < 8 && !oe_seen; n++) begin
         @(posedge clk_sys);
         #1;
         if (data_oe === 1'b1) begin
            oe_seen = 1'b1;
            dat = data_out;
         end
      end
      // Keep the strobe through one more edge with the answer standing
      @(posedge clk_sys);
      #1;
      rd_n = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      cs_n = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask
endmodule
`default_nettype wire

// ==== sim/test_interval_timer.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_interval_timer;
   logic       clk_sys;
   logic       rst_n;
   logic       cs_n;
   logic       rd_n;
   logic       wr_n;
   logic       psl;
   logic       psh;
   logic [7:0] data_in;
   logic [7:0] data_out;
   logic       data_oe;
   logic [2:0] timer_clk;
   logic [2:0] timer_gate;
   logic [2:0] timer_out;
   logic [7:0] d;
   logic       ok;
   int         miscompares = 0;
   int         checks = 0;

   // ---------------------------------------------------------------
   // Design, host model and clock
   // ---------------------------------------------------------------
   interval_timer dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .CS_N(cs_n),
      .RD_N(rd_n), .WR_N(wr_n), .PORT_SELECT_LOW(psl),
      .PORT_SELECT_HIGH(psh), .DATA_IN(data_in), .DATA_OUT(data_out),
      .DATA_OE(data_oe), .TIMER_CLK(timer_clk), .TIMER_GATE(timer_gate),
      .TIMER_OUT(timer_out));
   host_bus_model host (.clk_sys(clk_sys), .data_out(data_out),
      .data_oe(data_oe), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
      .port_select_low(psl), .port_select_high(psh), .data_in(data_in));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic conclude;
      $display("Comparisons %0d mismatches %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One timer clock pulse per count, phases of 4 system cycles
   task automatic tick(input int ch, input int n);
      repeat (n) begin
         repeat (4) @(posedge clk_sys);
         #1;
         timer_clk[ch] = 1'b0;
         repeat (4) @(posedge clk_sys);
         #1;
         timer_clk[ch] = 1'b1;
      end
      repeat (2) @(posedge clk_sys);
      #1;
   endtask

   task automatic out_is(input int ch, input logic e);
      check("timer output", {7'h00, e}, {7'h00, timer_out[ch]});
   endtask

   // Counts low output samples over n timer clocks
   task automatic lows(input int ch, input int n, input logic [7:0] e);
      int k;
      k = 0;
      repeat (n) begin
         tick(ch, 1);
         if (timer_out[ch] !== 1'b1) k++;
      end
      check("low clocks", e, 8'(k));
   endtask

   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      host.bus_read(a, d, ok);
      if (ok !== 1'b1) begin
         miscompares++;
         $display("CHECK FAILED read answer expected 1 seen 0");
         conclude();
      end else begin
         check("read byte", e, d);
         check("bus released", 8'h00, {7'h00, data_oe});
      end
   endtask

   task automatic load(input logic [1:0] a, input logic [7:0] cw,
                       input logic [7:0] lo);
      host.bus_write(2'h3, cw);
      host.bus_write(a, lo);
      host.bus_write(a, 8'h00);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic s_mode0;
      load(2'h0, 8'h30, 8'h04);
      out_is(0, 1'b0);
      tick(0, 2);
      timer_gate[0] = 1'b0;
      tick(0, 3);
      rd(2'h0, 8'h03);
      rd(2'h0, 8'h00);
      timer_gate[0] = 1'b1;
      tick(0, 2);
      out_is(0, 1'b0);
      tick(0, 1);
      out_is(0, 1'b1);
      host.bus_write(2'h0, 8'h02);
      tick(0, 3);
      out_is(0, 1'b0);
      host.bus_write(2'h0, 8'h00);
      tick(0, 2);
      out_is(0, 1'b0);
      tick(0, 1);
      out_is(0, 1'b1);
   endtask

   task automatic s_mode2;
      // Counter 0, low byte only access, so the channel 0 checks see it
      host.bus_write(2'h3, 8'h14);
      tick(0, 2);
      out_is(0, 1'b1);
      host.bus_write(2'h0, 8'h03);
      for (int i = 0; i < 6; i++) begin
         tick(0, 1);
         out_is(0, (i % 3) != 2);
      end
      timer_gate[0] = 1'b0;
      repeat (5) @(posedge clk_sys);
      #1;
      out_is(0, 1'b1);
      timer_gate[0] = 1'b1;
      tick(0, 3);
      out_is(0, 1'b0);
   endtask

   task automatic s_strobes;
      load(2'h2, 8'hB6, 8'h05);
      tick(2, 2);
      lows(2, 10, 8'h04);
      load(2'h0, 8'h38, 8'h03);
      out_is(0, 1'b1);
      lows(0, 8, 8'h01);
      timer_gate[1] = 1'b0;
      load(2'h1, 8'h72, 8'h03);
      tick(1, 2);
      out_is(1, 1'b1);
      timer_gate[1] = 1'b1;
      tick(1, 1);
      out_is(1, 1'b0);
      host.bus_write(2'h1, 8'h05);
      host.bus_write(2'h1, 8'h00);
      lows(1, 5, 8'h02);
      timer_gate[2] = 1'b0;
      load(2'h2, 8'hBA, 8'h02);
      timer_gate[2] = 1'b1;
      lows(2, 6, 8'h01);
   endtask

   task automatic s_latch;
      load(2'h0, 8'h31, 8'h10);
      tick(0, 3);
      host.bus_write(2'h3, 8'h00);
      tick(0, 2);
      rd(2'h0, 8'h08);
      rd(2'h0, 8'h00);
      host.bus_read(2'h3, d, ok);
      check("control read drive", 8'h00, {7'h00, ok});
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      timer_clk = 3'h7;
      timer_gate = 3'h7;
      repeat (12) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      s_mode0();
      s_mode2();
      s_strobes();
      s_latch();
      conclude();
   end
endmodule
`default_nettype wire
